// *** design/call_clear_exec.sv ***
// Executor for calls, watchdog clear and clear/invert/decrement file ops
// Register map, one aligned 32-bit word each; unused bits read zero
//   0x00 instruction   rw  [2:0] operation, [3] destination,
//                          [10:4] file address, [26:16] literal;
//                          a write launches the instruction
//   0x04 status        ro  [0] zero flag, [1] sleep flag, low active,
//                          [2] expiry flag, low active, [3] busy,
//                          [7:4] return stack pointer
//   0x08 accumulator   rw  [7:0]
//   0x0c high latch    rw  [6:0], upper program counter bits for calls
//   0x10 program count rw  [14:0]
//   0x14 watchdog      ro  [7:0] counter, [15:8] prescaler
//   0x18 file pointer  rw  [6:0], selects the word seen at 0x1c
//   0x1c file data     rw  [7:0] of the selected file register
//   0x20 stack top     ro  [14:0] most recent return address
//
// Operation codes
//   0 none, 1 literal call, 2 accumulator call, 3 watchdog clear,
//   4 invert, 5 zero file, 6 decrement, 7 zero accumulator
//
// Bus answers
//   Write response one edge after the later of address and data;
//   read data registered at the edge that takes the address.
//   Unmapped or read-only offsets, and any write while busy, answer
//   with a slave error and change nothing. A write with byte lane 0
//   off is answered OKAY and ignored.
//
// Timing
//   The phase counter runs freely. A launched instruction waits for
//   the next phase wrap, so it starts one to four clocks after the
//   write lands. Single-cycle operations act at the end of their four
//   phases; calls push at the end of the first cycle and load the
//   program counter at the end of the second.
//
// Flags
//   Calls leave every flag alone. Invert and decrement set the zero
//   flag from their result; both clear operations set it outright.
//
// Reset
//   Synchronous and active high. Every register, the return stack and
//   the file memory clear; both low-active flags read one; the bus
//   ready outputs rise on the first edge after release.
//
// Limitations
//   The return stack is 16 deep and wraps silently on overflow, so a
//   seventeenth nested call overwrites the oldest return address.
//   There is no sleep operation here, so the sleep flag is only ever
//   set. A watchdog expiry needs 2^18 clocks (256 prescaled ticks of
//   1024 clocks), far longer than a short test can wait.
//   The file memory sits in the state struct, which keeps the whole
//   block in one register but costs area; a real core would use RAM.
//
// Hazard
//   Core state is locked while an instruction runs, so software cannot
//   change an operand that the sequencer is about to read.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`include "call_clear_params.svh"

module call_clear_exec
   import call_clear_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     srst,
   input  wire axi_m2s_t axi_in,
   output axi_s2m_t      axi_out
);

   // All state in one packed struct; s_next is built once per clock
   state_t s_reg;
   state_t s_next;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   // Offsets with a register behind them
   function automatic logic reg_known(input logic [`ADDR_W-1:0] a);
      reg_known = (a == `OFS_INSTR)   || (a == `OFS_STATUS) ||
                  (a == `OFS_ACCUM)   || (a == `OFS_PCLATCH) ||
                  (a == `OFS_PC)      || (a == `OFS_WDOG)   ||
                  (a == `OFS_FADDR)   || (a == `OFS_FDATA)  ||
                  (a == `OFS_TOS);
   endfunction

   // Zero detect for the file-op results
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   // Outputs come straight from the state register
   assign axi_out = s_reg.axi;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      // Scratch values, each given a value first so no latch appears
      logic [7:0]          res;
      logic [31:0]         rd;
      logic                busy;
      logic                wr_ok;
      logic [`SP_W-1:0]    tos_idx;
      res     = 8'h00;
      rd      = 32'h0000_0000;
      busy    = s_reg.pend || (s_reg.st != ST_IDLE);
      wr_ok   = 1'b0;
      tos_idx = s_reg.sp - `SP_W'(1);
      s_next  = s_reg;

      // Write address and data channels are taken independently
      if (axi_in.awvalid && s_reg.axi.awready) begin
         s_next.aw_got = 1'b1;
         s_next.waddr  = axi_in.awaddr;
      end
      if (axi_in.wvalid && s_reg.axi.wready) begin
         s_next.w_got = 1'b1;
         s_next.wdata = axi_in.wdata;
         s_next.wstrb = axi_in.wstrb;
      end
      if (s_reg.axi.bvalid && axi_in.bready) begin
         s_next.axi.bvalid = 1'b0;
      end

      // Register write once both halves are in; core state is locked
      // while an instruction runs so software cannot race the sequencer
      if (s_reg.aw_got && s_reg.w_got && !s_reg.axi.bvalid) begin
         s_next.aw_got     = 1'b0;
         s_next.w_got      = 1'b0;
         s_next.axi.bvalid = 1'b1;
         wr_ok = reg_known(s_reg.waddr) && !busy &&
                 (s_reg.waddr != `OFS_STATUS) &&
                 (s_reg.waddr != `OFS_WDOG) && (s_reg.waddr != `OFS_TOS);
         s_next.axi.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         if (wr_ok && s_reg.wstrb[0]) begin
            unique case (s_reg.waddr)
               `OFS_INSTR: begin
                  s_next.ins.op   = op_t'(s_reg.wdata[`INS_OP_LSB +: 3]);
                  s_next.ins.dest = s_reg.wdata[`INS_DEST_BIT];
                  s_next.ins.f    = s_reg.wdata[`INS_F_LSB +: `FADDR_W];
                  s_next.ins.k    = s_reg.wdata[`INS_K_LSB +: `LIT_W];
                  s_next.pend     = 1'b1;
               end
               `OFS_ACCUM:   s_next.accum   = s_reg.wdata[7:0];
               `OFS_PCLATCH: s_next.pclatch = s_reg.wdata[`LATCH_W-1:0];
               `OFS_PC:      s_next.pc      = s_reg.wdata[`PC_W-1:0];
               `OFS_FADDR:   s_next.faddr   = s_reg.wdata[`FADDR_W-1:0];
               `OFS_FDATA:   s_next.fmem[s_reg.faddr] = s_reg.wdata[7:0];
               default:      s_next.faddr   = s_reg.faddr;
            endcase
         end
      end

      // Read channel: one read at a time, answered one edge after address
      // The word is built every cycle and caught only at the handshake
      unique case (axi_in.araddr)
         `OFS_INSTR:   rd = {5'h00, s_reg.ins.k, 5'h00, s_reg.ins.f,
                             s_reg.ins.dest, s_reg.ins.op};
         `OFS_STATUS:  rd = {24'h00_0000, s_reg.sp, busy, s_reg.expired_n,
                             s_reg.slept_n, s_reg.zero};
         `OFS_ACCUM:   rd = {24'h00_0000, s_reg.accum};
         `OFS_PCLATCH: rd = {25'h000_0000, s_reg.pclatch};
         `OFS_PC:      rd = {17'h0_0000, s_reg.pc};
         `OFS_WDOG:    rd = {16'h0000, s_reg.presc, s_reg.wdog};
         `OFS_FADDR:   rd = {25'h000_0000, s_reg.faddr};
         `OFS_FDATA:   rd = {24'h00_0000, s_reg.fmem[s_reg.faddr]};
         `OFS_TOS:     rd = {17'h0_0000, s_reg.stack[tos_idx]};
         default:      rd = 32'h0000_0000;
      endcase
      if (s_reg.axi.rvalid && axi_in.rready) begin
         s_next.axi.rvalid = 1'b0;
      end
      if (axi_in.arvalid && s_reg.axi.arready) begin
         s_next.axi.rvalid = 1'b1;
         s_next.axi.rdata  = rd;
         s_next.axi.rresp  = reg_known(axi_in.araddr) ? `RESP_OKAY
                                                      : `RESP_SLVERR;
      end

      // Four-phase instruction cycle, free running
      s_next.q = s_reg.q + 2'h1;

      // Watchdog: prescaler counts instruction cycles, counter counts
      // prescaler wraps; a counter wrap marks the timeout
      // A watchdog clear in the sequencer below overrides this tick
      if (s_reg.q == `PHASE_LAST) begin
         s_next.presc = s_reg.presc + `PRESC_W'(1);
         if (s_reg.presc == {`PRESC_W{1'b1}}) begin
            s_next.wdog = s_reg.wdog + `WDOG_W'(1);
            if (s_reg.wdog == {`WDOG_W{1'b1}}) begin
               s_next.expired_n = 1'b0;
            end
         end
      end

      // Sequencer: an instruction starts on Q1 and acts at its Q4
      unique case (s_reg.st)
         ST_IDLE: begin
            // Hold off until the phase wraps so every start is on Q1
            if (s_reg.pend && s_reg.q == `PHASE_LAST) begin
               s_next.pend = 1'b0;
               s_next.st   = ST_CYC1;
            end
         end
         ST_CYC1: begin
            if (s_reg.q == `PHASE_LAST) begin
               s_next.st = ST_IDLE;
               s_next.pc = s_reg.pc + `PC_W'(1);
               unique case (s_reg.ins.op)
                  OP_CALL, OP_CALLACC: begin
                     // Return address first; flags untouched
                     s_next.stack[s_reg.sp] = s_reg.pc + `PC_W'(1);
                     s_next.sp = s_reg.sp + `SP_W'(1);
                     s_next.pc = s_reg.pc;
                     s_next.st = ST_CYC2;
                  end
                  OP_WDCLR: begin
                     // Counter, prescaler and both flags move together
                     s_next.wdog      = '0;
                     s_next.presc     = '0;
                     s_next.expired_n = 1'b1;
                     s_next.slept_n   = 1'b1;
                  end
                  OP_INVERT, OP_DECR: begin
                     // Both share the destination select and zero flag
                     if (s_reg.ins.op == OP_INVERT) begin
                        res = ~s_reg.fmem[s_reg.ins.f];
                     end else begin
                        res = s_reg.fmem[s_reg.ins.f] - 8'h01;
                     end
                     if (s_reg.ins.dest) begin
                        s_next.fmem[s_reg.ins.f] = res;
                     end else begin
                        s_next.accum = res;
                     end
                     s_next.zero = is_zero(res);
                  end
                  OP_ZEROF: begin
                     s_next.fmem[s_reg.ins.f] = 8'h00;
                     s_next.zero = 1'b1;
                  end
                  OP_ZEROA: begin
                     s_next.accum = 8'h00;
                     s_next.zero  = 1'b1;
                  end
                  OP_NOP: begin
                     s_next.zero = s_reg.zero;
                  end
               endcase
            end
         end
         ST_CYC2: begin
            // Second cycle: the jump target lands in the program counter
            if (s_reg.q == `PHASE_LAST) begin
               s_next.st = ST_IDLE;
               if (s_reg.ins.op == OP_CALL) begin
                  s_next.pc = {s_reg.pclatch[6:3], s_reg.ins.k};
               end else begin
                  s_next.pc = {s_reg.pclatch, s_reg.accum};
               end
            end
         end
         default: begin
            // The unused state code falls back to idle
            s_next.st = ST_IDLE;
         end
      endcase

      // Ready only while the matching channel has room
      // Taken from next values so readiness never lags a capture
      s_next.axi.awready = !s_next.aw_got && !s_next.axi.bvalid;
      s_next.axi.wready  = !s_next.w_got && !s_next.axi.bvalid;
      s_next.axi.arready = !s_next.axi.rvalid;

      // Synchronous reset; memories cleared too so reads are defined
      // Applied last so it overrides every update above
      if (srst) begin
         s_next           = '0;
         s_next.st        = ST_IDLE;
         s_next.expired_n = `RST_EXPIRED_N;
         s_next.slept_n   = `RST_SLEPT_N;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // One flop bank for the whole state; reset is folded in above
   always_ff @(posedge clk_sys) begin
      s_reg <= s_next;
   end

endmodule

// *** design/call_clear_params.svh ***
// Offsets, field positions, reset values and timing counts for the executor
`ifndef CALL_CLEAR_PARAMS_SVH
`define CALL_CLEAR_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_INSTR     8'h00
`define OFS_STATUS    8'h04
`define OFS_ACCUM     8'h08
`define OFS_PCLATCH   8'h0c
`define OFS_PC        8'h10
`define OFS_WDOG      8'h14
`define OFS_FADDR     8'h18
`define OFS_FDATA     8'h1c
`define OFS_TOS       8'h20

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define ADDR_W        8
`define PC_W          15
`define LATCH_W       7
`define FADDR_W       7
`define LIT_W         11
`define SP_W          4
`define STACK_DEPTH   16
`define FILE_DEPTH    128
`define WDOG_W        8
`define PRESC_W       8

// ---------------------------------------------------------------
// Instruction word fields
// ---------------------------------------------------------------
`define INS_OP_LSB    0
`define INS_DEST_BIT  3
`define INS_F_LSB     4
`define INS_K_LSB     16

// ---------------------------------------------------------------
// Status word fields
// ---------------------------------------------------------------
`define ST_ZERO_BIT   0
`define ST_SLEPT_BIT  1
`define ST_EXPIRED_BIT 2
`define ST_BUSY_BIT   3
`define ST_SP_LSB     4

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RST_EXPIRED_N 1'b1
`define RST_SLEPT_N   1'b1
`define PHASE_LAST    2'h3
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// *** design/call_clear_pkg.sv ***
// Types shared by the call, clear and file operation executor
`include "call_clear_params.svh"

package call_clear_pkg;

   // ---------------------------------------------------------------
   // Operation codes and sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NOP     = 3'h0,
      OP_CALL    = 3'h1,
      OP_CALLACC = 3'h2,
      OP_WDCLR   = 3'h3,
      OP_INVERT  = 3'h4,
      OP_ZEROF   = 3'h5,
      OP_DECR    = 3'h6,
      OP_ZEROA   = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_CYC1  = 2'h1,
      ST_CYC2  = 2'h3
   } exec_st_t;

   // ---------------------------------------------------------------
   // AXI4-Lite channel bundles
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                 awvalid;
      logic [`ADDR_W-1:0]   awaddr;
      logic                 wvalid;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bready;
      logic                 arvalid;
      logic [`ADDR_W-1:0]   araddr;
      logic                 rready;
   } axi_m2s_t;

   typedef struct packed {
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } axi_s2m_t;

   typedef struct packed {
      op_t                  op;
      logic                 dest;
      logic [`FADDR_W-1:0]  f;
      logic [`LIT_W-1:0]    k;
   } instr_t;

   // ---------------------------------------------------------------
   // Whole state of the executor
   // ---------------------------------------------------------------
   typedef struct packed {
      axi_s2m_t                                  axi;
      logic                                      aw_got;
      logic                                      w_got;
      logic [`ADDR_W-1:0]                        waddr;
      logic [31:0]                               wdata;
      logic [3:0]                                wstrb;
      exec_st_t                                  st;
      logic [1:0]                                q;
      logic                                      pend;
      instr_t                                    ins;
      logic [7:0]                                accum;
      logic [`LATCH_W-1:0]                       pclatch;
      logic [`PC_W-1:0]                          pc;
      logic                                      zero;
      logic                                      expired_n;
      logic                                      slept_n;
      logic [`WDOG_W-1:0]                        wdog;
      logic [`PRESC_W-1:0]                       presc;
      logic [`SP_W-1:0]                          sp;
      logic [`STACK_DEPTH-1:0][`PC_W-1:0]        stack;
      logic [`FILE_DEPTH-1:0][7:0]               fmem;
      logic [`FADDR_W-1:0]                       faddr;
   } state_t;

endpackage

// *** verification/call_clear_and_file_ops_tb_top.sv ***
// Self-checking bench for the call and file operation executor
`include "call_clear_params.svh"
module call_clear_and_file_ops_tb_top
   import call_clear_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [1:0] OK = `RESP_OKAY;
   localparam logic [1:0] ERR = `RESP_SLVERR;
   logic        clk_sys, srst;
   axi_m2s_t    m;
   axi_s2m_t    s;
   logic [31:0] v;
   int          cyc = 0, mismatches = 0, cmp_count = 0, el;

   call_clear_exec DUT (.clk_sys(clk_sys), .srst(srst), .axi_in(m),
      .axi_out(s));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Cycle count doubles as the hang limit
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Ready is sampled at the falling edge, so no race with the slave
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] rs;
      m.awaddr <= a;
      m.wdata <= d;
      m.awvalid <= 1'b1;
      m.wvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         {aw, w, b, rs} = {s.awready, s.wready, s.bvalid, s.bresp};
         @(posedge clk_sys);
         if (aw) m.awvalid <= 1'b0;
         if (w) m.wvalid <= 1'b0;
      end while (!b);
      chk(32'(rs), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] er);
      logic ar, r;
      logic [1:0] rs;
      m.araddr <= a;
      m.arvalid <= 1'b1;
      do begin
         @(negedge clk_sys);
         {ar, r, rs, d} = {s.arready, s.rvalid, s.rresp, s.rdata};
         @(posedge clk_sys);
         if (ar) m.arvalid <= 1'b0;
      end while (!r);
      chk(32'(rs), 32'(er));
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, v, OK);
      chk(v, e);
   endtask
   // Launch, optionally poke a write that busy must refuse, poll busy
   task automatic exec(input logic [31:0] ins, input bit probe);
      int t0;
      wr(`OFS_INSTR, ins, OK);
      t0 = cyc;
      if (probe) wr(`OFS_ACCUM, 32'h99, ERR);
      do rd(`OFS_STATUS, v, OK); while (v[3] !== 1'b0);
      el = cyc - t0;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rdc(`OFS_STATUS, 32'h6);
      rdc(`OFS_PC, 32'h0);
      wr(`OFS_STATUS, 32'h1, ERR);
      wr(8'h3c, 32'h1, ERR);
      rd(8'h3c, v, ERR);
      rdc(`OFS_STATUS, 32'h6);
   endtask
   // Top file register, both destinations, zero and non-zero results
   task automatic t_file();
      logic [8:0]  pre [7] = '{9'h1ff, 9'h15a, 9'h101, 9'h000, 9'h133,
                               9'h000, 9'h000};
      logic [11:0] ins [7] = '{12'h7f4, 12'h7fc, 12'h7fe, 12'h7f6,
                               12'h7f5, 12'h7f4, 12'h007};
      logic [7:0]  acc [7] = '{8'h0, 8'h0, 8'h0, 8'hff, 8'hff, 8'hff, 8'h0};
      logic [7:0]  fv  [7] = '{8'hff, 8'ha5, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
      logic [3:0]  st  [7] = '{4'h7, 4'h6, 4'h7, 4'h6, 4'h7, 4'h6, 4'h7};
      wr(`OFS_FADDR, 32'h7f, OK);
      foreach (pre[i]) begin
         if (pre[i][8]) wr(`OFS_FDATA, 32'(pre[i][7:0]), OK);
         exec(32'(ins[i]), 1'b0);
         chk(32'(el <= 10), 1);
         rdc(`OFS_ACCUM, 32'(acc[i]));
         rdc(`OFS_FDATA, 32'(fv[i]));
         rdc(`OFS_STATUS, 32'(st[i]));
      end
   endtask
   // Zero flag is left set beforehand, so a call must not touch it
   task automatic t_calls();
      wr(`OFS_PCLATCH, 32'h78, OK);
      wr(`OFS_PC, 32'h123, OK);
      exec(32'h05a5_0001, 1'b1);
      chk(32'(el >= 10), 1);
      rdc(`OFS_PC, 32'h7da5);
      rdc(`OFS_TOS, 32'h124);
      rdc(`OFS_STATUS, 32'h17);
      wr(`OFS_ACCUM, 32'h3c, OK);
      wr(`OFS_PCLATCH, 32'h55, OK);
      wr(`OFS_PC, 32'h200, OK);
      exec(32'h2, 1'b1);
      chk(32'(el >= 10), 1);
      rdc(`OFS_PC, 32'h553c);
      rdc(`OFS_TOS, 32'h201);
      rdc(`OFS_STATUS, 32'h27);
   endtask
   // Expiry needs 2^18 clocks, out of reach here; let the counter tick
   task automatic t_wdog();
      while (cyc < 3000) @(posedge clk_sys);
      rd(`OFS_STATUS, v, OK);
      chk(v & 32'h6, 32'h6);
      rd(`OFS_WDOG, v, OK);
      chk(32'(v[7:0] != 8'h00), 1);
      exec(32'h3, 1'b0);
      rd(`OFS_STATUS, v, OK);
      chk(v & 32'h6, 32'h6);
      rd(`OFS_WDOG, v, OK);
      chk(32'(v[7:0]), 32'h0);
      chk(32'(v[15:8] < 8'h40), 1);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      m = '0;
      m.wstrb = 4'hf;
      m.bready = 1'b1;
      m.rready = 1'b1;
      srst = 1'b1;
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_file();
      t_calls();
      t_wdog();
      report_and_stop();
   end
endmodule

// *** verification/call_clear_exec_properties.sv ***
// Bus handshake checks bound to the call and file operation executor
`include "call_clear_params.svh"
module call_clear_exec_properties
   import call_clear_pkg::*;
(
   input wire logic     clk_sys,
   input wire logic     srst,
   input wire axi_m2s_t axi_in,
   input wire axi_s2m_t axi_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------------------------
   // Handshake sequences
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // Address and data taken together, the way the bench offers them
   sequence aw_w_taken;
      axi_in.awvalid && axi_out.awready && axi_in.wvalid && axi_out.wready;
   endsequence
   sequence b_stall;
      axi_out.bvalid && !axi_in.bready;
   endsequence
   sequence r_stall;
      axi_out.rvalid && !axi_in.rready;
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   b_hold_a: assert property (b_stall |=> axi_out.bvalid
      && $stable(axi_out.bresp)) else $error("write answer not held");
   r_hold_a: assert property (r_stall |=> axi_out.rvalid
      && $stable(axi_out.rdata)) else $error("read answer not held");
   b_latency_a: assert property (aw_w_taken |-> ##2 axi_out.bvalid)
      else $error("write answer late");
   r_latency_a: assert property (axi_in.arvalid && axi_out.arready
      |=> axi_out.rvalid) else $error("read answer late");
   wready_low_a: assert property (axi_out.bvalid |-> !axi_out.awready
      && !axi_out.wready) else $error("write ready while answering");
   arready_low_a: assert property (axi_out.rvalid |-> !axi_out.arready)
      else $error("read ready while answering");
   b_clear_a: assert property (axi_out.bvalid && axi_in.bready
      |=> !axi_out.bvalid) else $error("write answer repeated");
   r_clear_a: assert property (axi_out.rvalid && axi_in.rready
      |=> !axi_out.rvalid) else $error("read answer repeated");
   resp_code_a: assert property (axi_out.bvalid |-> axi_out.bresp
      inside {`RESP_OKAY, `RESP_SLVERR}) else $error("bad write code");
endmodule

bind call_clear_exec call_clear_exec_properties u_props (
   .clk_sys(clk_sys),
   .srst   (srst),
   .axi_in (axi_in),
   .axi_out(axi_out)
);
